// ===== core/isb_pkg.sv
// Shared constants and types for the buffered I2C slave
package isb_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int ISB_BYTE_W = 8;
    localparam int ISB_ADDR_W = 7;
    localparam int ISB_RAM_DEPTH = 32;
    localparam int ISB_RAM_AW = 5;
    localparam int ISB_FIFO_DEPTH = 8;
    localparam int ISB_FIFO_W = 9;
    localparam int ISB_CFG_W = 10;

    // ------------------------------------------------------------
    // Field positions, codes and reset values
    // ------------------------------------------------------------
    localparam int ISB_RW_BIT = 0;
    localparam int ISB_MSB = 7;
    localparam logic [2:0] ISB_LAST_BIT = 3'h7;
    localparam logic [4:0] ISB_TENBIT_HDR = 5'h1e;
    localparam logic [7:0] ISB_BYTE_RST = 8'h00;
    localparam logic [4:0] ISB_PTR_RST = 5'h00;
    localparam logic [9:0] ISB_CFG_RST = 10'h000;

    // ------------------------------------------------------------
    // Bus rate and link sampling clock
    // ------------------------------------------------------------
    localparam int ISB_BUS_MAX_KHZ = 400;
    localparam int ISB_LINK_CLK_KHZ = 33333;
    localparam int ISB_OVERSAMPLE_MIN = 16;

    // Kind of byte event passed from the link to the core side
    typedef enum logic [1:0] {
        ISB_EV_ADDR,
        ISB_EV_DATA,
        ISB_EV_RDREQ
    } isb_kind_e;

endpackage

// ===== core/isb_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module isb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two so the pointers wrap cleanly
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("isb_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Handshakes; full and empty come straight from the count
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];

    // Storage, written only on an accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== core/isb_top.sv
// Byte-oriented I2C slave with stalling mode and a RAM buffer mode
//
// Overview of operation
// - The block is only ever a bus slave and both receives and transmits bytes.
// - Bus clocks up to 400 kHz are served and the master keeps below that rate.
// - A 7-bit address is compared with the configured address in hardware.
// - Ten-bit headers are not decoded but passed to the CPU as received bytes.
// - Work is done byte by byte and the CPU only hears about whole bytes.
// - Firmware may poll status flags or use the interrupt request.
// - While enabled the block owns the data and clock pins over general I/O.
// - In default mode the bus is stalled after each address and data byte.
// - The stall lasts until the CPU reads the byte or supplies one to send.
// - In buffer mode the master sees a 32-byte RAM for its writes and reads.
// - The master sets the buffer pointer and the block advances it per byte.
// - In buffer mode the bus is never stalled and bytes move at bus speed.
`timescale 1ns/1ps
`default_nettype none
module isb_top
    import isb_pkg::*;
#(
    parameter int LINK_CLK_KHZ = isb_pkg::ISB_LINK_CLK_KHZ,
    parameter int FIFO_DEPTH = isb_pkg::ISB_FIFO_DEPTH
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link sampling clock
    input wire logic link_clk,
    // Configuration
    input wire logic enable,
    input wire logic ram_buffer_mode,
    input wire logic tenbit_en,
    input wire logic [isb_pkg::ISB_ADDR_W-1:0] own_addr,
    input wire logic irq_en,
    // Bus pins, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic pin_override,
    // Received bytes to the CPU
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [isb_pkg::ISB_BYTE_W-1:0] rx_data,
    output logic rx_is_addr,
    // Transmit byte from the CPU
    output logic tx_req,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [isb_pkg::ISB_BYTE_W-1:0] tx_data,
    // CPU port to the buffer RAM
    input wire logic ram_we,
    input wire logic [isb_pkg::ISB_RAM_AW-1:0] ram_addr,
    input wire logic [isb_pkg::ISB_BYTE_W-1:0] ram_wdata,
    output logic [isb_pkg::ISB_BYTE_W-1:0] ram_rdata,
    // Interrupt request
    output logic irq
);
    import isb_pkg::*;

    // Sampling the bus needs enough link clocks per bus bit
    initial begin
        if (LINK_CLK_KHZ < ISB_BUS_MAX_KHZ * ISB_OVERSAMPLE_MIN) begin
            $error("isb_top: link clock too slow for the bus rate");
        end
    end

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_RMACK, ST_HOLD, ST_SKIP
    } isb_link_e;

    typedef enum logic [1:0] {
        SY_IDLE, SY_WAIT_POP, SY_WAIT_TX
    } isb_sys_e;

    // ------------------------------------------------------------
    // Link domain: synchronisers
    // ------------------------------------------------------------
    logic lrst_s1_reg, lrst_s2_reg;
    logic [ISB_CFG_W-1:0] cfg_s1_reg, cfg_s2_reg;
    logic scl_s1_reg, scl_s2_reg, scl_d_reg;
    logic sda_s1_reg, sda_s2_reg, sda_d_reg;
    logic ack_s1_reg, ack_s2_reg;
    logic ack_reg;
    logic [ISB_BYTE_W-1:0] tx_out_reg;

    // Reset is carried into the link domain by two flops
    always_ff @(posedge link_clk) begin
        lrst_s1_reg <= rst;
        lrst_s2_reg <= lrst_s1_reg;
    end

    // Configuration is quasi-static; each bit gets two flops
    always_ff @(posedge link_clk) begin
        if (lrst_s2_reg) begin
            cfg_s1_reg <= ISB_CFG_RST;
            cfg_s2_reg <= ISB_CFG_RST;
        end else begin
            cfg_s1_reg <= {enable, ram_buffer_mode, tenbit_en, own_addr};
            cfg_s2_reg <= cfg_s1_reg;
        end
    end

    // Pins and the returning acknowledge toggle
    always_ff @(posedge link_clk) begin
        if (lrst_s2_reg) begin
            {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
            {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            scl_s1_reg <= scl_i;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
            ack_s1_reg <= ack_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    logic l_en, l_buf, l_tenbit;
    logic [ISB_ADDR_W-1:0] l_addr;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign {l_en, l_buf, l_tenbit, l_addr} = cfg_s2_reg;
    assign scl_rise = scl_s2_reg && !scl_d_reg;
    assign scl_fall = !scl_s2_reg && scl_d_reg;
    assign bus_start = scl_s2_reg && scl_d_reg && !sda_s2_reg && sda_d_reg;
    assign bus_stop = scl_s2_reg && scl_d_reg && sda_s2_reg && !sda_d_reg;

    // ------------------------------------------------------------
    // Link domain: bit engine
    // ------------------------------------------------------------
    isb_link_e state_reg;
    logic [ISB_BYTE_W-1:0] shift_reg;
    logic [2:0] cnt_reg;
    logic rw_reg;
    logic phase_reg;
    logic sda_oe_reg, scl_oe_reg;
    logic ev_req_reg;
    isb_kind_e ev_kind_reg;
    logic [ISB_BYTE_W-1:0] ev_data_reg;
    logic ev_busy;
    logic [ISB_BYTE_W-1:0] in_byte;
    logic addr_hit;
    logic send_ev;
    isb_kind_e send_kind;

    assign ev_busy = (ev_req_reg != ack_s2_reg);
    assign in_byte = {shift_reg[ISB_MSB-1:0], sda_s2_reg};
    // Own address, or any ten-bit header when firmware asks for those
    assign addr_hit = (in_byte[ISB_MSB:1] == l_addr)
        || (l_tenbit && in_byte[ISB_MSB:3] == ISB_TENBIT_HDR);

    // Byte engine; start and stop act at once in any state, even mid-byte
    always_ff @(posedge link_clk) begin
        if (lrst_s2_reg || !l_en) begin
            state_reg <= ST_IDLE;
            shift_reg <= ISB_BYTE_RST;
            cnt_reg <= '0;
            rw_reg <= 1'b0;
            phase_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (bus_start) begin
            state_reg <= ST_ADDR;
            cnt_reg <= '0;
            phase_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_SKIP: begin
                    sda_oe_reg <= 1'b0;
                end
                ST_ADDR: if (scl_rise) begin
                    shift_reg <= in_byte;
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == ISB_LAST_BIT) begin
                        rw_reg <= in_byte[ISB_RW_BIT];
                        state_reg <= addr_hit ? ST_ACK : ST_SKIP;
                    end
                end
                ST_WDATA: if (scl_rise) begin
                    shift_reg <= in_byte;
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == ISB_LAST_BIT) begin
                        state_reg <= ST_ACK;
                    end
                end
                // First fall drives the acknowledge, second ends it
                ST_ACK: if (scl_fall) begin
                    phase_reg <= !phase_reg;
                    sda_oe_reg <= !phase_reg;
                    if (phase_reg) begin
                        state_reg <= ST_HOLD;
                    end
                end
                // Clock stretched here in default mode until the core side answers
                ST_HOLD: if (!ev_busy || l_buf) begin
                    cnt_reg <= '0;
                    if (rw_reg) begin
                        shift_reg <= tx_out_reg;
                        sda_oe_reg <= !tx_out_reg[ISB_MSB];
                        state_reg <= ST_RDATA;
                    end else begin
                        state_reg <= ST_WDATA;
                    end
                end
                ST_RDATA: if (scl_fall) begin
                    if (cnt_reg == ISB_LAST_BIT) begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= ST_RMACK;
                    end else begin
                        shift_reg <= {shift_reg[ISB_MSB-1:0], 1'b0};
                        sda_oe_reg <= !shift_reg[ISB_MSB-1];
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                // Master acknowledge; a NACK ends the read
                ST_RMACK: begin
                    if (scl_rise && !phase_reg) begin
                        phase_reg <= !sda_s2_reg;
                        if (sda_s2_reg) begin
                            state_reg <= ST_SKIP;
                        end
                    end else if (scl_fall && phase_reg) begin
                        phase_reg <= 1'b0;
                        state_reg <= ST_HOLD;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Which completed byte raises an event for the core side
    always_comb begin
        send_ev = 1'b0;
        send_kind = ISB_EV_DATA;
        if (l_en && !bus_start && !bus_stop) begin
            if (state_reg == ST_ADDR && scl_rise && cnt_reg == ISB_LAST_BIT
                    && addr_hit) begin
                send_ev = 1'b1;
                send_kind = ISB_EV_ADDR;
            end else if (state_reg == ST_WDATA && scl_rise
                    && cnt_reg == ISB_LAST_BIT) begin
                send_ev = 1'b1;
            end else if (state_reg == ST_RMACK && scl_rise && !phase_reg
                    && !sda_s2_reg) begin
                send_ev = 1'b1;
                send_kind = ISB_EV_RDREQ;
            end
        end
    end

    // Event toggle; kind and byte stay still until acknowledged
    always_ff @(posedge link_clk) begin
        if (lrst_s2_reg) begin
            ev_req_reg <= 1'b0;
            ev_kind_reg <= ISB_EV_DATA;
            ev_data_reg <= ISB_BYTE_RST;
        end else if (send_ev && !ev_busy) begin
            ev_req_reg <= !ev_req_reg;
            ev_kind_reg <= send_kind;
            ev_data_reg <= in_byte;
        end
    end

    // Stretch lags the hold state by a cycle so data settles first
    always_ff @(posedge link_clk) begin
        if (lrst_s2_reg) begin
            scl_oe_reg <= 1'b0;
        end else begin
            scl_oe_reg <= (state_reg == ST_HOLD) && !l_buf && l_en;
        end
    end

    // Open drain: the pins are only ever pulled low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
    assign pin_override = l_en;

    // ------------------------------------------------------------
    // Core domain: event receiver
    // ------------------------------------------------------------
    logic ev_s1_reg, ev_s2_reg;
    isb_sys_e sys_reg;
    logic need_tx_reg;
    logic first_reg;
    logic [ISB_RAM_AW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [ISB_BYTE_W-1:0] ram_mem [ISB_RAM_DEPTH];
    logic [ISB_BYTE_W-1:0] ram_rdata_reg;
    logic irq_reg;
    logic pending, buf_go, link_we;
    logic fifo_in_valid, fifo_in_ready;
    logic [ISB_FIFO_W-1:0] fifo_out;

    always_ff @(posedge clk) begin
        if (rst) begin
            ev_s1_reg <= 1'b0;
            ev_s2_reg <= 1'b0;
        end else begin
            ev_s1_reg <= ev_req_reg;
            ev_s2_reg <= ev_s1_reg;
        end
    end

    // Kind and byte are only read once the toggle has arrived
    assign pending = (sys_reg == SY_IDLE) && (ev_s2_reg != ack_reg);
    // A CPU write to the RAM takes the port; the event waits a cycle
    assign buf_go = pending && ram_buffer_mode && !ram_we;
    assign link_we = buf_go && ev_kind_reg == ISB_EV_DATA && !first_reg;
    assign fifo_in_valid = pending && !ram_buffer_mode
        && ev_kind_reg != ISB_EV_RDREQ;

    // Default mode parks each byte here for the CPU
    isb_fifo #(
        .WIDTH(ISB_FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({ev_kind_reg == ISB_EV_ADDR, ev_data_reg}),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(fifo_out)
    );

    assign rx_is_addr = fifo_out[ISB_FIFO_W-1];
    assign rx_data = fifo_out[ISB_BYTE_W-1:0];
    assign tx_req = (sys_reg == SY_WAIT_TX);
    assign tx_ready = tx_req;

    // Service sequence; the acknowledge toggle releases the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            sys_reg <= SY_IDLE;
            ack_reg <= 1'b0;
            need_tx_reg <= 1'b0;
            tx_out_reg <= ISB_BYTE_RST;
        end else begin
            unique case (sys_reg)
                SY_IDLE: begin
                    if (buf_go) begin
                        ack_reg <= ev_s2_reg;
                        if (ev_kind_reg != ISB_EV_DATA) begin
                            tx_out_reg <= ram_mem[rd_ptr_reg];
                        end
                    end else if (pending && !ram_buffer_mode) begin
                        if (ev_kind_reg == ISB_EV_RDREQ) begin
                            sys_reg <= SY_WAIT_TX;
                        end else if (fifo_in_ready) begin
                            need_tx_reg <= ev_kind_reg == ISB_EV_ADDR
                                && ev_data_reg[ISB_RW_BIT];
                            sys_reg <= SY_WAIT_POP;
                        end
                    end
                end
                // Bus stays held until the CPU has taken the byte
                SY_WAIT_POP: if (!rx_valid) begin
                    if (need_tx_reg) begin
                        sys_reg <= SY_WAIT_TX;
                    end else begin
                        ack_reg <= ev_s2_reg;
                        sys_reg <= SY_IDLE;
                    end
                end
                SY_WAIT_TX: if (tx_valid) begin
                    tx_out_reg <= tx_data;
                    ack_reg <= ev_s2_reg;
                    sys_reg <= SY_IDLE;
                end
            endcase
        end
    end

    // Buffer pointers: first written byte sets both, then they advance
    always_ff @(posedge clk) begin
        if (rst) begin
            first_reg <= 1'b1;
            wr_ptr_reg <= ISB_PTR_RST;
            rd_ptr_reg <= ISB_PTR_RST;
        end else if (buf_go) begin
            unique case (ev_kind_reg)
                ISB_EV_ADDR: begin
                    first_reg <= !ev_data_reg[ISB_RW_BIT];
                    if (ev_data_reg[ISB_RW_BIT]) begin
                        rd_ptr_reg <= rd_ptr_reg + 1'b1;
                    end
                end
                ISB_EV_DATA: begin
                    first_reg <= 1'b0;
                    if (first_reg) begin
                        wr_ptr_reg <= ev_data_reg[ISB_RAM_AW-1:0];
                        rd_ptr_reg <= ev_data_reg[ISB_RAM_AW-1:0];
                    end else begin
                        wr_ptr_reg <= wr_ptr_reg + 1'b1;
                    end
                end
                ISB_EV_RDREQ: rd_ptr_reg <= rd_ptr_reg + 1'b1;
                default: first_reg <= 1'b1;
            endcase
        end
    end

    // Buffer RAM; one write port shared by the bus and the CPU
    always_ff @(posedge clk) begin
        if (link_we) begin
            ram_mem[wr_ptr_reg] <= ev_data_reg;
        end else if (ram_we) begin
            ram_mem[ram_addr] <= ram_wdata;
        end
    end

    // CPU read data comes from a register
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_rdata_reg <= ISB_BYTE_RST;
        end else begin
            ram_rdata_reg <= ram_mem[ram_addr];
        end
    end

    assign ram_rdata = ram_rdata_reg;

    // Interrupt mirrors the pollable flags
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_en && (rx_valid || tx_req);
        end
    end

    assign irq = irq_reg;

endmodule
`default_nettype wire

// ===== bench/isb_top_monitor.sv
// Port-level checks for the I2C slave
`timescale 1ns/1ps
`default_nettype none
module isb_top_monitor (
    // Clock, reset and configuration
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic ram_buffer_mode,
    input wire logic irq_en,
    // Bus side
    input wire logic scl_oe,
    input wire logic pin_override,
    // CPU side
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic tx_req,
    input wire logic tx_valid,
    input wire logic ram_we,
    input wire logic [4:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // CPU write, then the same place held for a read
    sequence wr_then_rd;
        ram_we ##1 (!ram_we && $stable(ram_addr));
    endsequence
    // Byte popped and no transmit byte asked for afterwards
    sequence popped_no_tx;
        $fell(rx_valid) ##1 !tx_req;
    endsequence
    buf_no_stall_a: assert property (ram_buffer_mode |-> !scl_oe)
        else $error("stretch in buffer mode");
    stall_release_a: assert property (popped_no_tx |-> ##[0:60] !scl_oe)
        else $error("stretch kept after pop");
    irq_set_a: assert property (irq_en && rx_valid |=> irq)
        else $error("irq missing");
    tx_take_a: assert property (tx_valid && tx_req |=> !tx_req)
        else $error("tx request stuck");
    rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("rx byte lost");
    one_byte_a: assert property (rx_valid && rx_ready && !ram_buffer_mode |=> !rx_valid)
        else $error("second byte queued");
    ram_read_a: assert property (wr_then_rd |=> ram_rdata == $past(ram_wdata, 2))
        else $error("ram read wrong");
    pin_take_a: assert property ($rose(enable) |-> ##[1:40] pin_override)
        else $error("pins not taken");
endmodule
bind isb_top isb_top_monitor mon (.*);
`default_nettype wire

// ===== bench/isb_master_model.sv
// Behavioural I2C bus master
`timescale 1ns/1ps
`default_nettype none
module isb_master_model (
    // Slave pull-downs in, wire levels out
    input wire logic scl_oe,
    input wire logic sda_oe,
    output logic scl_i,
    output logic sda_i
);
    localparam int T = 1250; // High phase of the clock; a whole bit takes 2.25 T, keeps below 400 kHz
    logic scl_m = 1'b1;
    logic sda_m = 1'b1;
    // Pull-ups hold both lines high unless someone pulls low
    assign scl_i = scl_m & ~scl_oe;
    assign sda_i = sda_m & ~sda_oe;
    // One clock pulse; a stretching slave delays the high phase
    task automatic bit_io(input logic b, output logic r);
        #(T/4) sda_m = b;
        #T scl_m = 1'b1;
        wait (scl_i);
        #(T/2) r = sda_i;
        #(T/2) scl_m = 1'b0;
    endtask
    task automatic start();
        #(T/4) sda_m = 1'b1;
        #T scl_m = 1'b1;
        wait (scl_i);
        #T sda_m = 1'b0;
        #T scl_m = 1'b0;
    endtask
    task automatic stop();
        #(T/4) sda_m = 1'b0;
        #T scl_m = 1'b1;
        wait (scl_i);
        #T sda_m = 1'b1;
        #T;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] w, input logic ai, output logic [7:0] r,
                        output logic ao);
        for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
        bit_io(ai, ao);
    endtask
endmodule
`default_nettype wire

// ===== bench/isb_top_tb.sv
// Self-checking bench for the I2C slave
`timescale 1ns/1ps
`default_nettype none
module isb_top_tb;
    import isb_pkg::*;
    logic clk = 1'b0, rst = 1'b1, link_clk = 1'b0, enable = 1'b0, ram_buffer_mode = 1'b0;
    logic tenbit_en = 1'b0, irq_en = 1'b1, rx_ready = 1'b0, tx_valid = 1'b0, ram_we = 1'b0;
    logic [6:0] own_addr = 7'h2a;
    logic [7:0] tx_data = 8'h00, ram_wdata = 8'h00, rx_data, ram_rdata;
    logic [4:0] ram_addr = 5'h00;
    logic scl_i, sda_i, scl_oe, sda_oe, pin_override, rx_valid, rx_is_addr, tx_req, tx_ready, irq;
    int n_fail = 0, tests_run = 0, cyc = 0;
    isb_top uut (.*, .scl_o(), .sda_o());
    isb_master_model mst (.*);
    // Link clock offset so its edges never line up with the core clock
    initial forever #2.5 clk = ~clk;
    initial #4 forever #15 link_clk = ~link_clk;
    // Hang guard, a little past the end of the whole sequence of transfers
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait for a flag, always at least one edge
    task automatic wt(ref logic s);
        int k;
        k = 0;
        do @(posedge clk); while (s !== 1'b1 && k++ < 9000);
        if (s !== 1'b1) n_fail++;
    endtask
    // Take one byte once the bus is held, checking the hold lasts
    task automatic pop(input logic [7:0] b, input logic a);
        wt(rx_valid);
        wt(scl_oe);
        chk("rx_data", rx_data, b);
        chk("rx_is_addr", 8'(rx_is_addr), 8'(a));
        repeat (40) @(posedge clk);
        chk("held", 8'(scl_oe), 8'h01);
        chk("irq", 8'(irq), 8'h01);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask
    task automatic t_write();
        logic a;
        logic [7:0] r;
        fork
            begin
                mst.start();
                mst.xfer(8'h54, 1'b1, r, a);
                chk("ack", 8'(a), 8'h00);
                mst.xfer(8'ha5, 1'b1, r, a);
                mst.stop();
            end
            begin
                pop(8'h54, 1'b1);
                pop(8'ha5, 1'b0);
            end
        join
    endtask
    task automatic t_nack();
        logic a;
        logic [7:0] r;
        mst.start();
        mst.xfer(8'h22, 1'b1, r, a);
        chk("nack", 8'(a), 8'h01);
        mst.xfer(8'h00, 1'b1, r, a);
        mst.stop();
        chk("rx_valid", 8'(rx_valid), 8'h00);
    endtask
    task automatic t_read();
        logic a;
        logic [7:0] r;
        fork
            begin
                mst.start();
                mst.xfer(8'h55, 1'b1, r, a);
                mst.xfer(8'hff, 1'b1, r, a);
                mst.stop();
                chk("tx byte", r, 8'h3c);
            end
            begin
                pop(8'h55, 1'b1);
                wt(tx_req);
                chk("tx_ready", 8'(tx_ready), 8'h01);
                tx_data <= 8'h3c;
                tx_valid <= 1'b1;
                @(posedge clk);
                tx_valid <= 1'b0;
            end
        join
    endtask
    // Offset 5, two writes, then read back across a CPU-written place
    task automatic t_buf();
        logic a;
        logic [7:0] r;
        logic [7:0] e [3] = '{8'h11, 8'h22, 8'h77};
        ram_buffer_mode <= 1'b1;
        ram_addr <= 5'h07;
        ram_wdata <= 8'h77;
        ram_we <= 1'b1;
        @(posedge clk);
        ram_we <= 1'b0;
        mst.start();
        mst.xfer(8'h54, 1'b1, r, a);
        mst.xfer(8'h05, 1'b1, r, a);
        mst.xfer(8'h11, 1'b1, r, a);
        mst.xfer(8'h22, 1'b1, r, a);
        chk("buf ack", 8'(a), 8'h00);
        mst.start();
        mst.xfer(8'h55, 1'b1, r, a);
        for (int i = 0; i < 3; i++) begin
            mst.xfer(8'hff, i == 2, r, a);
            chk("buf read", r, e[i]);
        end
        mst.stop();
        @(posedge clk);
        ram_addr <= 5'h06;
        repeat (2) @(posedge clk);
        chk("ram_rdata", ram_rdata, 8'h22);
    endtask
    // Ten-bit header is acknowledged and handed over as an address byte
    task automatic t_ten();
        logic a;
        logic [7:0] r;
        tenbit_en <= 1'b1;
        fork
            begin
                mst.start();
                mst.xfer(8'hf0, 1'b1, r, a);
                chk("ten ack", 8'(a), 8'h00);
                mst.stop();
            end
            pop(8'hf0, 1'b1);
        join
        tenbit_en <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        chk("pins idle", 8'(pin_override | scl_oe | sda_oe | rx_valid), 8'h00);
        enable <= 1'b1;
        wt(pin_override);
        chk("pins taken", 8'(pin_override), 8'h01);
        repeat (30) @(posedge clk);
        t_write();
        t_nack();
        t_read();
        t_ten();
        @(posedge clk);
        t_buf();
        tally_and_finish();
    end
endmodule
`default_nettype wire
